// *** hw/ims_pkg.sv ***
package ims_pkg;

	// Clock rate and the 3 s step of every cycling display.
	localparam int CLK_HZ = 40000000;
	localparam int STEP_MS = 3000;
	localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;

	// Map numbering, custom map store and value limits (speeds in 100 rpm units).
	localparam int NUM_CMAP = 5;
	localparam int NUM_PT = 4;
	localparam logic [4:0] MAP_RST = 5'h01;
	localparam logic [4:0] CMAP_BASE = 5'h0a;
	localparam logic [4:0] MAP_LAST = 5'h0e;
	localparam logic [8:0] SPD_LIM = 9'h12c;
	localparam logic [5:0] ANG_LIM = 6'h27;
	localparam logic [8:0] SPD_STEP = 9'h032;
	localparam logic [5:0] ANG_RST = 6'h0a;

	// Largest digit offered at each entry position.
	localparam logic [3:0] MAP_TENS_MAX = 4'h1;
	localparam logic [3:0] ANG_TENS_MAX = 4'h3;
	localparam logic [3:0] SPD_TOP_MAX = 4'h2;
	localparam logic [3:0] DIG_MAX = 4'h9;

	// Register byte offsets and bus responses.
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MAP = 8'h04;
	localparam logic [7:0] REG_CSEL = 8'h08;
	localparam logic [7:0] REG_CDATA = 8'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Display symbol codes; 5'h00 to 5'h09 are the digits.
	localparam logic [4:0] DSP_BLANK = 5'h10;
	localparam logic [4:0] DSP_C_UP = 5'h11;
	localparam logic [4:0] DSP_C_LO = 5'h12;
	localparam logic [4:0] DSP_DASH = 5'h13;
	localparam logic [4:0] DSP_N = 5'h14;
	localparam logic [4:0] DSP_W = 5'h15;
	localparam logic [4:0] DSP_STORE = 5'h16;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'h0, ST_RELEASE = 4'h1, ST_ITEMS = 4'h3, ST_SHOW_MAP = 4'h2,
		ST_DIGIT = 4'h6, ST_CHECK = 4'h7, ST_CONFIRM = 4'h5, ST_STORE = 4'h4,
		ST_STORED = 4'hc, ST_CMAP = 4'hd, ST_CSHOW = 4'hf, ST_PSEL = 4'he,
		ST_BOOT = 4'h9
	} ims_state_e;

	typedef enum logic [1:0] {ED_MAP = 2'h0, ED_ANG = 2'h1, ED_SPD = 2'h2} ims_kind_e;

endpackage

// *** hw/ims_menu_top.sv ***
`timescale 1ns/10ps
// How it works
// - Menu only if magnet held at power-up then released, else normal run.
// - Map selection first shows the currently active map index.
// - Tens digit cycles 0 to 1, three seconds each; magnet accepts it.
// - Units digit then cycles 0 to 9, three seconds each; magnet accepts, completing the index.
// - The active map index, the new one if 14 or less, is shown as confirmation.
// - New setting goes to persistent storage, then a store pattern shows.
// - After that the menu ends: speed display and ignition armed.
// - Five custom maps, each four speed and angle pairs.
// - First speed of each custom map is always zero and never edited.
// - Speeds change in 100 rpm steps, angles in one degree steps.
// - Custom map speeds strictly rise from first to fourth point.
// - Editable speeds stay below 30000 rpm.
// - Every angle stays below 39 degrees.
// - Custom map item cycles map indices three seconds each; magnet picks.
// - Chosen map values show in order speed0, angle0 up to angle3.
// - Speeds wider than two digits show as timed digit groups.
// - Custom maps are indices 10 to 14, selected like preset maps.
module ims_menu_top import ims_pkg::*; #(
	parameter int STEP_CYCLES = STEP_CYC
) (
	// Clock and synchronous reset.
	input wire logic CLK,
	input wire logic RST,
	// AXI4-Lite register slave.
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Operator magnet switch and engine speed in 100 rpm units.
	input wire logic MAG_IN,
	input wire logic [8:0] ENG_SPEED,
	// Two-digit display, ignition arm and active map.
	output logic [4:0] DISP_L,
	output logic [4:0] DISP_R,
	output logic IGN_ARM,
	output logic [4:0] ACTIVE_MAP,
	// Persistent storage write port.
	output logic NV_REQ,
	output logic [4:0] NV_ADDR,
	output logic [15:0] NV_DATA,
	input wire logic NV_DONE
);

	ims_state_e state_ff, st_prev_ff;
	ims_kind_e kind_ff;
	logic [26:0] cnt_ff;
	logic tick, acc_p, mag_prev_ff, item_ff, sh_ph_ff, wr_fire, spd_ok;
	logic [2:0] cm_sel_ff, sh_idx_ff, pidx_ff;
	logic [1:0] pos_ff, pt;
	logic [3:0] dig_ff, dmax;
	logic [8:0] acc_ff, cur_spd, sh_spd;
	logic [5:0] cur_ang;
	logic [4:0] map_ff, csel_ff;
	logic [8:0] cm_spd_ff [0:NUM_CMAP-1][0:NUM_PT-1];
	logic [5:0] cm_ang_ff [0:NUM_CMAP-1][0:NUM_PT-1];
	logic aw_got_ff, w_got_ff, wstrb0_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [4:0] disp_l_ff, disp_r_ff, act_ff, nv_addr_ff;
	logic ign_ff, nv_req_ff, awr_ff, wr_ff, bv_ff, arr_ff, rv_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [15:0] nv_data_ff;

	// Splits a value below 100 into two digit codes.
	function automatic logic [9:0] pair(input logic [6:0] v);
		logic [6:0] t;
		logic [6:0] u;
		t = v / 7'd10;
		u = v % 7'd10;
		pair = {1'b0, t[3:0], 1'b0, u[3:0]};
	endfunction

	// Step timer restarts on every state change; tick marks each 3 s slot.
	// Tick is held off in the first cycle of a new state, so a stale count cannot cut it short.
	assign tick = cnt_ff == 27'(STEP_CYCLES - 1) && state_ff == st_prev_ff;
	always_ff @(posedge CLK) begin
		if (RST || state_ff != st_prev_ff || tick) begin
			cnt_ff <= 27'h0;
		end else begin
			cnt_ff <= cnt_ff + 27'h1;
		end
		st_prev_ff <= RST ? ST_BOOT : state_ff;
	end

	// Magnet actuation is taken on its rising edge.
	always_ff @(posedge CLK) begin
		mag_prev_ff <= RST ? 1'b1 : MAG_IN;
	end
	assign acc_p = MAG_IN & ~mag_prev_ff;

	// Selected values, digit limit and speed checks for the edit in progress.
	assign pt = pidx_ff[2:1];
	assign cur_spd = cm_spd_ff[cm_sel_ff][pt];
	assign cur_ang = cm_ang_ff[cm_sel_ff][pt];
	assign sh_spd = cm_spd_ff[cm_sel_ff][sh_idx_ff[2:1]];
	assign spd_ok = acc_ff < SPD_LIM && acc_ff > cm_spd_ff[cm_sel_ff][pt - 2'h1] &&
		(pt == 2'h3 || acc_ff < cm_spd_ff[cm_sel_ff][pt + 2'h1]);
	always_comb begin
		dmax = DIG_MAX;
		if (pos_ff == 2'h0) begin
			case (kind_ff)
				ED_MAP: dmax = MAP_TENS_MAX;
				ED_ANG: dmax = ANG_TENS_MAX;
				default: dmax = SPD_TOP_MAX;
			endcase
		end
	end

	// Menu sequencer with custom map store and active map.
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_ff <= ST_BOOT;
			kind_ff <= ED_MAP;
			item_ff <= 1'b0;
			cm_sel_ff <= 3'h0;
			sh_idx_ff <= 3'h0;
			sh_ph_ff <= 1'b0;
			pidx_ff <= 3'h1;
			pos_ff <= 2'h0;
			dig_ff <= 4'h0;
			acc_ff <= 9'h0;
			map_ff <= MAP_RST;
			for (int m = 0; m < NUM_CMAP; m++) begin
				for (int p = 0; p < NUM_PT; p++) begin
					cm_spd_ff[m][p] <= 9'(SPD_STEP * p);
					cm_ang_ff[m][p] <= ANG_RST;
				end
			end
		end else begin
			if (wr_fire && awaddr_ff == REG_MAP && wstrb0_ff && wdata_ff[4:0] <= MAP_LAST) begin
				map_ff <= wdata_ff[4:0];
			end
			case (state_ff)
				ST_BOOT: state_ff <= MAG_IN ? ST_RELEASE : ST_NORMAL;
				ST_RELEASE: if (!MAG_IN) begin
					state_ff <= ST_ITEMS;
				end
				ST_ITEMS: if (acc_p) begin
					state_ff <= item_ff ? ST_CMAP : ST_SHOW_MAP;
					cm_sel_ff <= 3'h0;
				end else if (tick) begin
					item_ff <= ~item_ff;
				end
				ST_SHOW_MAP: if (tick) begin
					state_ff <= ST_DIGIT;
					kind_ff <= ED_MAP;
					pos_ff <= 2'h0;
					dig_ff <= 4'h0;
					acc_ff <= 9'h0;
				end
				ST_DIGIT: if (acc_p) begin
					acc_ff <= 9'(acc_ff * 9'd10 + {5'h0, dig_ff});
					dig_ff <= 4'h0;
					if (pos_ff == (kind_ff == ED_SPD ? 2'h2 : 2'h1)) begin
						state_ff <= ST_CHECK;
					end else begin
						pos_ff <= pos_ff + 2'h1;
					end
				end else if (tick) begin
					dig_ff <= dig_ff == dmax ? 4'h0 : dig_ff + 4'h1;
				end
				ST_CHECK: begin
					case (kind_ff)
						ED_MAP: begin
							if (acc_ff <= {4'h0, MAP_LAST}) begin
								map_ff <= acc_ff[4:0];
							end
							state_ff <= ST_CONFIRM;
						end
						ED_ANG: begin
							if (acc_ff < {3'h0, ANG_LIM}) begin
								cm_ang_ff[cm_sel_ff][pt] <= acc_ff[5:0];
							end
							state_ff <= ST_STORE;
						end
						default: begin
							if (spd_ok) begin
								cm_spd_ff[cm_sel_ff][pt] <= acc_ff;
							end
							state_ff <= ST_STORE;
						end
					endcase
				end
				ST_CONFIRM: if (tick) begin
					state_ff <= ST_STORE;
				end
				ST_STORE: if (NV_DONE) begin
					state_ff <= ST_STORED;
				end
				ST_STORED: if (tick) begin
					state_ff <= ST_NORMAL;
				end
				ST_CMAP: if (acc_p) begin
					state_ff <= ST_CSHOW;
					sh_idx_ff <= 3'h0;
					sh_ph_ff <= 1'b0;
				end else if (tick) begin
					cm_sel_ff <= cm_sel_ff == 3'h4 ? 3'h0 : cm_sel_ff + 3'h1;
				end
				ST_CSHOW: if (tick) begin
					if (!sh_idx_ff[0] && !sh_ph_ff) begin
						sh_ph_ff <= 1'b1;
					end else begin
						sh_ph_ff <= 1'b0;
						if (sh_idx_ff == 3'h7) begin
							state_ff <= ST_PSEL;
							pidx_ff <= 3'h1;
						end else begin
							sh_idx_ff <= sh_idx_ff + 3'h1;
						end
					end
				end
				ST_PSEL: if (acc_p) begin
					state_ff <= ST_DIGIT;
					kind_ff <= pidx_ff[0] ? ED_ANG : ED_SPD;
					pos_ff <= 2'h0;
					dig_ff <= 4'h0;
					acc_ff <= 9'h0;
				end else if (tick) begin
					pidx_ff <= pidx_ff == 3'h7 ? 3'h1 : pidx_ff + 3'h1;
				end
				default: state_ff <= ST_NORMAL;
			endcase
		end
	end

	// Display, arm, active map and storage port, all registered.
	always_ff @(posedge CLK) begin
		if (RST) begin
			{disp_l_ff, disp_r_ff} <= {DSP_BLANK, DSP_BLANK};
		end else begin
			case (state_ff)
				ST_NORMAL: {disp_l_ff, disp_r_ff} <= pair(7'(ENG_SPEED / 9'd10));
				ST_ITEMS: {disp_l_ff, disp_r_ff} <= {DSP_C_UP, item_ff ? DSP_C_LO : DSP_DASH};
				ST_SHOW_MAP, ST_CONFIRM: {disp_l_ff, disp_r_ff} <= pair({2'h0, map_ff});
				ST_DIGIT: {disp_l_ff, disp_r_ff} <= {DSP_BLANK, 1'b0, dig_ff};
				ST_STORE, ST_STORED: {disp_l_ff, disp_r_ff} <= {DSP_STORE, DSP_STORE};
				ST_CMAP: {disp_l_ff, disp_r_ff} <= pair({2'h0, CMAP_BASE + {2'h0, cm_sel_ff}});
				ST_CSHOW: begin
					if (sh_idx_ff[0]) begin
						{disp_l_ff, disp_r_ff} <= pair({1'b0, cm_ang_ff[cm_sel_ff][sh_idx_ff[2:1]]});
					end else if (sh_ph_ff) begin
						disp_l_ff <= 5'(sh_spd % 9'd10);
						disp_r_ff <= 5'h00;
					end else begin
						{disp_l_ff, disp_r_ff} <= pair(7'(sh_spd / 9'd10));
					end
				end
				ST_PSEL: {disp_l_ff, disp_r_ff} <= {pidx_ff[0] ? DSP_W : DSP_N, 3'h0, pt};
				ST_BOOT, ST_RELEASE: {disp_l_ff, disp_r_ff} <= {DSP_DASH, DSP_DASH};
				default: {disp_l_ff, disp_r_ff} <= {DSP_BLANK, DSP_BLANK};
			endcase
		end
		ign_ff <= !RST && state_ff == ST_NORMAL;
		act_ff <= RST ? MAP_RST : map_ff;
		nv_req_ff <= !RST && state_ff == ST_STORE && !NV_DONE;
		nv_addr_ff <= (RST || kind_ff == ED_MAP) ? 5'h00 : 5'({cm_sel_ff, pt} + 5'h01);
		nv_data_ff <= (RST || kind_ff == ED_MAP) ? {11'h0, map_ff} : {1'b0, cur_ang, cur_spd};
	end

	// AXI4-Lite write path: address and data taken in either order.
	assign wr_fire = aw_got_ff & w_got_ff & ~bv_ff;
	always_ff @(posedge CLK) begin
		if (RST) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awr_ff <= 1'b0;
			wr_ff <= 1'b0;
			bv_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			awaddr_ff <= 8'h0;
			wdata_ff <= 32'h0;
			wstrb0_ff <= 1'b0;
			csel_ff <= 5'h0;
		end else begin
			awr_ff <= !aw_got_ff && !(S_AXI_AWVALID && awr_ff);
			wr_ff <= !w_got_ff && !(S_AXI_WVALID && wr_ff);
			if (S_AXI_AWVALID && awr_ff) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && wr_ff) begin
				w_got_ff <= 1'b1;
				wdata_ff <= S_AXI_WDATA;
				wstrb0_ff <= S_AXI_WSTRB[0];
			end
			if (wr_fire) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bv_ff <= 1'b1;
				bresp_ff <= (awaddr_ff == REG_STATUS || awaddr_ff == REG_MAP ||
					awaddr_ff == REG_CSEL || awaddr_ff == REG_CDATA) ? RESP_OKAY : RESP_SLVERR;
				if (awaddr_ff == REG_CSEL && wstrb0_ff) begin
					csel_ff <= wdata_ff[4:0];
				end
			end else if (bv_ff && S_AXI_BREADY) begin
				bv_ff <= 1'b0;
			end
		end
	end

	// AXI4-Lite read path: one read under way, answered the cycle after the address.
	always_ff @(posedge CLK) begin
		if (RST) begin
			arr_ff <= 1'b0;
			rv_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= RESP_OKAY;
		end else if (S_AXI_ARVALID && arr_ff) begin
			arr_ff <= 1'b0;
			rv_ff <= 1'b1;
			rresp_ff <= RESP_OKAY;
			case (S_AXI_ARADDR)
				REG_STATUS: rdata_ff <= {23'h0, state_ff, map_ff};
				REG_MAP: rdata_ff <= {27'h0, map_ff};
				REG_CSEL: rdata_ff <= {27'h0, csel_ff};
				REG_CDATA: rdata_ff <= csel_ff[4:2] > 3'h4 ? 32'h0 :
					{17'h0, cm_ang_ff[csel_ff[4:2]][csel_ff[1:0]], cm_spd_ff[csel_ff[4:2]][csel_ff[1:0]]};
				default: begin
					rdata_ff <= 32'h0;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (rv_ff && S_AXI_RREADY) begin
			rv_ff <= 1'b0;
			arr_ff <= 1'b1;
		end else if (!rv_ff) begin
			arr_ff <= 1'b1;
		end
	end

	// Port drivers, each straight from its flip-flop.
	assign S_AXI_AWREADY = awr_ff;
	assign S_AXI_WREADY = wr_ff;
	assign S_AXI_BVALID = bv_ff;
	assign S_AXI_BRESP = bresp_ff;
	assign S_AXI_ARREADY = arr_ff;
	assign S_AXI_RVALID = rv_ff;
	assign S_AXI_RDATA = rdata_ff;
	assign S_AXI_RRESP = rresp_ff;
	assign DISP_L = disp_l_ff;
	assign DISP_R = disp_r_ff;
	assign IGN_ARM = ign_ff;
	assign ACTIVE_MAP = act_ff;
	assign NV_REQ = nv_req_ff;
	assign NV_ADDR = nv_addr_ff;
	assign NV_DATA = nv_data_ff;

	// Checks on the sequencer, limits and outputs.
	a_boot_menu_entry: assert property (@(posedge CLK) disable iff (RST)
		state_ff == ST_BOOT |=> state_ff == (($past(MAG_IN)) ? ST_RELEASE : ST_NORMAL))
		else $error("power-up entry wrong");
	a_show_cur_map: assert property (@(posedge CLK) disable iff (RST)
		$rose(state_ff == ST_SHOW_MAP) |=> disp_r_ff == 5'(map_ff % 5'd10))
		else $error("current map not shown");
	a_tens_digit_range: assert property (@(posedge CLK) disable iff (RST)
		state_ff == ST_DIGIT && kind_ff == ED_MAP && pos_ff == 2'h0 |-> dig_ff <= 4'h1)
		else $error("map tens digit out of range");
	a_digit_steps: assert property (@(posedge CLK) disable iff (RST)
		state_ff == ST_DIGIT && tick && !acc_p |=> dig_ff != $past(dig_ff))
		else $error("digit did not advance");
	a_store_pattern: assert property (@(posedge CLK) disable iff (RST)
		state_ff == ST_STORE && NV_DONE |=> ##1 disp_l_ff == DSP_STORE && !nv_req_ff)
		else $error("store pattern missing");
	a_resume_arm: assert property (@(posedge CLK) disable iff (RST)
		state_ff == ST_STORED && tick |=> ##1 ign_ff)
		else $error("ignition not armed");
	a_speed_order: assert property (@(posedge CLK) disable iff (RST)
		cm_spd_ff[cm_sel_ff][0] == 9'h0 && cm_spd_ff[cm_sel_ff][1] > 9'h0 &&
		cm_spd_ff[cm_sel_ff][2] > cm_spd_ff[cm_sel_ff][1] &&
		cm_spd_ff[cm_sel_ff][3] > cm_spd_ff[cm_sel_ff][2] && cm_spd_ff[cm_sel_ff][3] < SPD_LIM)
		else $error("custom speeds out of order");
	a_angle_limit: assert property (@(posedge CLK) disable iff (RST)
		cur_ang < ANG_LIM)
		else $error("angle limit broken");
	a_cmap_range: assert property (@(posedge CLK) disable iff (RST)
		state_ff == ST_CMAP |-> cm_sel_ff < 3'h5 && map_ff <= MAP_LAST)
		else $error("custom map index out of range");
	a_invalid_kept: assert property (@(posedge CLK) disable iff (RST)
		state_ff == ST_CHECK && kind_ff == ED_SPD && !spd_ok |=> cur_spd == $past(cur_spd))
		else $error("invalid speed stored");

endmodule // ims_menu_top

// *** verification/ims_operator.sv ***
`timescale 1ns/10ps
module ims_operator import ims_pkg::*; (
	// Clock, reset and bench commands.
	input wire logic clk,
	input wire logic rst,
	input wire logic arm,
	input wire logic any_s,
	input wire logic hold,
	input wire logic [4:0] tgt_l,
	input wire logic [4:0] tgt_r,
	input wire logic [3:0] nv_lat,
	// Device display and storage port.
	input wire logic [4:0] disp_l,
	input wire logic [4:0] disp_r,
	input wire logic nv_req,
	output logic mag,
	output logic done,
	output logic nv_done
);
	logic busy_ff, chg_ff, hit;
	logic [4:0] snap_l_ff, snap_r_ff;
	logic [1:0] hit_ff;
	logic [3:0] nv_cnt_ff;

	// A target counts only on a display that moved on since arming.
	assign hit = any_s ? (disp_l === tgt_l || disp_r === tgt_l) :
		(disp_l === tgt_l && disp_r === tgt_r);
	// The magnet is held at power-up or for a three-cycle press.
	assign mag = hold || (hit_ff != 2'h0);

	// The operator waits for the wanted value, then actuates the switch.
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (rst) begin
			busy_ff <= 1'b0;
			hit_ff <= 2'h0;
		end else if (hit_ff != 2'h0) begin
			hit_ff <= hit_ff - 2'h1;
			done <= (hit_ff == 2'h1);
		end else if (arm) begin
			busy_ff <= 1'b1;
			chg_ff <= 1'b0;
			snap_l_ff <= disp_l;
			snap_r_ff <= disp_r;
		end else if (busy_ff) begin
			chg_ff <= chg_ff || disp_l !== snap_l_ff || disp_r !== snap_r_ff;
			if (chg_ff && hit) begin
				hit_ff <= 2'h3;
				busy_ff <= 1'b0;
			end
		end
	end

	// Storage answers after a chosen latency with a one-cycle done.
	always_ff @(posedge clk) begin
		if (rst || !nv_req || nv_done) begin
			nv_cnt_ff <= 4'h0;
			nv_done <= 1'b0;
		end else begin
			nv_cnt_ff <= nv_cnt_ff + 4'h1;
			nv_done <= (nv_cnt_ff == nv_lat);
		end
	end
endmodule // ims_operator

// *** verification/testbench.sv ***
`timescale 1ns/10ps
module testbench import ims_pkg::*; ();
	localparam int STEPS = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [8:0] eng = 9'h000;
	logic awready, wready, bvalid, arready, rvalid, ign, mag, op_done, nv_req, nv_done;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [4:0] disp_l, disp_r, amap, nv_addr, v;
	logic [15:0] nv_data;
	logic arm = 1'b0, any_s = 1'b0, hold = 1'b0;
	logic [4:0] tgt_l = 5'h0, tgt_r = 5'h0;
	logic [3:0] nv_lat = 4'h1;
	logic [33:0] q_bus[$];
	logic [20:0] q_nv[$];
	logic [4:0] mt[3] = '{5'h00, 5'h01, 5'h01};
	logic [4:0] mu[3] = '{5'h04, 5'h02, 5'h05};
	logic [4:0] me[3] = '{5'h04, 5'h0c, 5'h01};
	// Custom edits: parameter shown, entered digits, and the expected {angle, speed} after it.
	logic [4:0] cl[4] = '{DSP_W, DSP_W, DSP_N, DSP_N};
	logic [4:0] cr[4] = '{5'h00, 5'h00, 5'h02, 5'h02};
	logic [4:0] ct[4] = '{5'h01, 5'h03, 5'h01, 5'h01};
	logic [4:0] cu[4] = '{5'h03, 5'h09, 5'h02, 5'h09};
	logic [4:0] ch[4] = '{5'h00, 5'h00, 5'h05, 5'h09};
	logic [14:0] ce[4] = '{15'h1a00, 15'h1400, 15'h147d, 15'h1464};
	int failures = 0, total_checks = 0, seed;

	// Device under test with a short display step.
	ims_menu_top #(.STEP_CYCLES(STEPS)) u_ims_menu_top (.CLK(clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(b_rdy),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(r_rdy),
		.MAG_IN(mag), .ENG_SPEED(eng), .DISP_L(disp_l), .DISP_R(disp_r), .IGN_ARM(ign),
		.ACTIVE_MAP(amap), .NV_REQ(nv_req), .NV_ADDR(nv_addr), .NV_DATA(nv_data),
		.NV_DONE(nv_done));

	// Operator with magnet and persistent storage.
	ims_operator u_ims_operator (.clk(clk), .rst(rst), .arm(arm), .any_s(any_s),
		.hold(hold), .tgt_l(tgt_l), .tgt_r(tgt_r), .nv_lat(nv_lat), .disp_l(disp_l),
		.disp_r(disp_r), .nv_req(nv_req), .mag(mag), .done(op_done), .nv_done(nv_done));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 clk = ~clk;
	end

	// Compare tasks for queued responses and for port levels.
	task automatic cmp_resp(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_port(input logic [4:0] got, input logic [4:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Each completed response is matched with the oldest note of its kind.
	always @(posedge clk) begin
		if (bvalid === 1'b1 && b_rdy) cmp_resp({32'h0, bresp}, q_bus.pop_front());
		if (rvalid === 1'b1 && r_rdy) cmp_resp({rresp, rdata}, q_bus.pop_front());
		if (nv_req === 1'b1 && nv_done === 1'b1) cmp_resp({nv_addr, nv_data}, q_nv.pop_front());
	end

	// Write with address and data offered together, each released when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ad, wd;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				aw_v <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				w_v <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		b_rdy <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		araddr <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		ar_v <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		r_rdy <= 1'b0;
		@(posedge clk);
	endtask

	// Map register write, read back and active map level.
	task automatic reg_map(input logic [4:0] d, input logic [3:0] s, input logic [4:0] e);
		q_bus.push_back({32'h0, RESP_OKAY});
		axi_wr(REG_MAP, {27'h0, d}, s);
		q_bus.push_back({RESP_OKAY, 27'h0, e});
		axi_rd(REG_MAP);
		cmp_port(amap, e);
	endtask

	// Select a custom point and read its stored pair.
	task automatic cdata(input logic [4:0] idx, input logic [14:0] e);
		q_bus.push_back({32'h0, RESP_OKAY});
		axi_wr(REG_CSEL, {27'h0, idx}, 4'hf);
		q_bus.push_back({RESP_OKAY, 17'h0, e});
		axi_rd(REG_CDATA);
	endtask

	// Reset with or without the magnet held through power-up.
	task automatic do_reset(input logic h);
		hold <= h;
		rst <= 1'b1;
		eng <= 9'($urandom % 300);
		nv_lat <= 4'($urandom % 8);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		hold <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// The operator presses when the display shows the target.
	task automatic press(input logic [4:0] l, input logic [4:0] r, input logic a);
		int n;
		tgt_l <= l;
		tgt_r <= r;
		any_s <= a;
		arm <= 1'b1;
		@(posedge clk);
		arm <= 1'b0;
		n = 0;
		while (op_done !== 1'b1 && n < 40 * STEPS) begin
			@(posedge clk);
			n++;
		end
		cmp_port({4'h0, op_done}, 5'h01);
	endtask

	task automatic wait_r(input logic [4:0] e);
		int n;
		n = 0;
		while (disp_r !== e && n < 20 * STEPS) begin
			@(posedge clk);
			n++;
		end
		cmp_port(disp_r, e);
	endtask

	task automatic wait_ign(input logic [4:0] e);
		int n;
		n = 0;
		while (ign !== 1'b1 && n < 60 * STEPS) begin
			@(posedge clk);
			n++;
		end
		cmp_port({4'h0, ign}, 5'h01);
		cmp_port(amap, e);
		cmp_port(disp_l, 5'(eng / 100));
		cmp_port(disp_r, 5'((eng / 10) % 10));
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence: registers, map selection, custom map edits.
	initial begin
		seed = $urandom(7);
		do_reset(1'b0);
		cmp_port({4'h0, ign}, 5'h01);
		reg_map(5'h0f, 4'hf, MAP_RST);
		reg_map(5'h0c, 4'h0, MAP_RST);
		reg_map(MAP_LAST, 4'hf, MAP_LAST);
		v = 5'($urandom % 15);
		reg_map(v, 4'hf, v);
		for (int p = 0; p < NUM_PT; p++) begin
			cdata(5'(16 + p), {ANG_RST, 9'(p * 50)});
		end
		cdata(5'h14, 15'h0);
		q_bus.push_back({32'h0, RESP_SLVERR});
		axi_wr(8'h10, 32'h1, 4'hf);
		q_bus.push_back({RESP_SLVERR, 32'h0});
		axi_rd(8'h10);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			do_reset(1'b1);
			cmp_port({4'h0, ign}, 5'h00);
			press(DSP_C_UP, DSP_DASH, 1'b0);
			wait_r(MAP_RST);
			press(mt[i], 5'h00, 1'b1);
			q_nv.push_back({5'h00, 11'h0, me[i]});
			press(mu[i], 5'h00, 1'b1);
			wait_r(5'(me[i] % 10));
			wait_r(DSP_STORE);
			wait_ign(me[i]);
			$display("test map select %0d done", i);
		end
		for (int i = 0; i < 4; i++) begin
			do_reset(1'b1);
			press(DSP_C_UP, DSP_C_LO, 1'b0);
			press(5'h01, 5'h02, 1'b0);
			wait_r(5'h05);
			press(cl[i], cr[i], 1'b0);
			press(ct[i], 5'h00, 1'b1);
			q_nv.push_back({5'(9 + cr[i]), 1'b0, ce[i]});
			press(cu[i], 5'h00, 1'b1);
			if (i > 1) press(ch[i], 5'h00, 1'b1);
			wait_ign(MAP_RST);
			cdata(5'(8 + cr[i]), ce[i]);
			$display("test custom edit %0d done", i);
		end
		final_report();
	end

	// A hang is cut short well after the expected run length.
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		final_report();
	end
endmodule // testbench
